// file: rtl/compact_timer.sv
// holds: the compact 10-bit timer with apb register access
// assumes: apb master on clk_i, synchronous active-high reset
//
// Summary of operation
// - separate match flags for comparator a and comparator p.
// - inverted output always mirrors the main output.
// - compare low write goes to buffer; high write commits both bytes.
// - high byte read captures low byte into buffer; low read returns buffer.
// - ten-bit counter counts up on each selected timer tick.
// - p compares three top bits; a compares all ten bits.
// - software clears the counter only via run enable rising; hardware also clears it on overflow or match.
// - counter self clears on overflow or selected match; only the match raises a flag.
// - pause holds the counter; clearing pause resumes from held value.
// - clock select picks sys/4, sys, high/16, high/64 or sub clock.
// - run enable low stops counting and keeps the counter value.
// - run enable rising resets output to initial level in compare mode, not in pwm.
// - period field gives multiples of 128 ticks; zero means 1024.
// - clear select zero makes a p match reset the counter.
// - mode field: 00 compare, 10 pwm, 11 timer, 01 undefined.
// - timer mode output is held low; output function unused.
// - compare mode a match: keep, low, high or toggle output.
// - pwm mode: force inactive, force active or pass pwm waveform.
// - a match requesting the current initial level shows no change.
// - clear select one clears on a match or overflow; zero on p or overflow; pwm ignores.
// - initial level bit sets pre-match level or pwm active level.
// - polarity bit inverts the main output except in timer mode.
//
// Decided for this implementation: the register addresses and the APB slave port.
`timescale 1ns/10ps
module compact_timer (
	input  wire logic        clk_i,
	input  wire logic        rst_i,
	input  wire logic        psel_i,
	input  wire logic        penable_i,
	input  wire logic        pwrite_i,
	input  wire logic [7:0]  paddr_i,
	input  wire logic [31:0] pwdata_i,
	output logic [31:0]      prdata_o,
	output logic             pready_o,
	output logic             pslverr_o,
	output logic             match_a_flag_o,
	output logic             match_p_flag_o,
	output logic             timer_out_o,
	output logic             timer_out_inverted_o
);
	logic [7:0]  control_0;
	logic [7:0]  control_1;
	logic [9:0]  counter;
	logic [9:0]  compare_a_value;
	logic [7:0]  hold_buffer;
	logic [7:0]  counter_low_snap;
	logic [15:0] sub_divide;
	logic        match_a_flag;
	logic        match_p_flag;
	logic        out_level;
	logic        run_prev;
	logic [31:0] next_rdata;
	logic        next_err;
	logic        tick;
	logic        wr_acc;
	logic        rd_acc;
	logic        run_rise;
	logic        advance;
	logic        match_a;
	logic        match_p;
	logic        overflow;
	logic        clear_cnt;
	logic        pwm_raw;
	logic        main_level;

	logic                             run_enable;
	logic                             pause_bit;
	logic [2:0]                       clock_select;
	logic [2:0]                       period_field;
	compact_timer_pkg::mode_e         mode_select;
	logic [1:0]                       output_function;
	logic                             output_initial_level;
	logic                             output_polarity;
	logic                             duty_period_swap;
	logic                             clear_select;

	assign run_enable           = control_0[compact_timer_pkg::C0_RUN];
	assign pause_bit            = control_0[compact_timer_pkg::C0_PAUSE];
	assign clock_select         = control_0[compact_timer_pkg::C0_CLKSEL_LSB +: 3];
	assign period_field         = control_0[compact_timer_pkg::C0_PERIOD_LSB +: 3];
	assign mode_select          = compact_timer_pkg::mode_e'(control_1[compact_timer_pkg::C1_MODE_LSB +: 2]);
	assign output_function      = control_1[compact_timer_pkg::C1_OUTFN_LSB +: 2];
	assign output_initial_level = control_1[compact_timer_pkg::C1_INIT_LEVEL];
	assign output_polarity      = control_1[compact_timer_pkg::C1_POLARITY];
	assign duty_period_swap     = control_1[compact_timer_pkg::C1_SWAP];
	assign clear_select         = control_1[compact_timer_pkg::C1_CLEAR_SEL];

	// ================================================================
	// apb slave: zero wait states
	assign pready_o = 1'b1;
	assign wr_acc   = psel_i && penable_i && pwrite_i;
	assign rd_acc   = psel_i && penable_i && !pwrite_i;

	function automatic logic addr_is(input logic [7:0] a, input logic [7:0] b);
		addr_is = (a == b);
	endfunction

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			control_0 <= compact_timer_pkg::CONTROL_RESET;
			control_1 <= compact_timer_pkg::CONTROL_RESET;
			sub_divide <= compact_timer_pkg::SUB_DIV_RESET;
		end else if (wr_acc) begin
			if (addr_is(paddr_i, compact_timer_pkg::ADDR_CONTROL_0)) begin
				control_0 <= pwdata_i[7:0];
			end else if (addr_is(paddr_i, compact_timer_pkg::ADDR_CONTROL_1)) begin
				control_1 <= pwdata_i[7:0];
			end else if (addr_is(paddr_i, compact_timer_pkg::ADDR_SUB_DIVIDE)) begin
				sub_divide <= pwdata_i[15:0];
			end
		end
	end

	// shared holding buffer and compare register
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			hold_buffer     <= 8'h00;
			compare_a_value <= 10'h000;
		end else if (wr_acc && addr_is(paddr_i, compact_timer_pkg::ADDR_COMPARE_LOW)) begin
			hold_buffer <= pwdata_i[7:0];
		end else if (wr_acc && addr_is(paddr_i, compact_timer_pkg::ADDR_COMPARE_HIGH)) begin
			compare_a_value <= {pwdata_i[1:0], hold_buffer};
		end else if (rd_acc && addr_is(paddr_i, compact_timer_pkg::ADDR_COUNTER_HIGH)) begin
			hold_buffer <= counter_low_snap;
		end else if (rd_acc && addr_is(paddr_i, compact_timer_pkg::ADDR_COMPARE_HIGH)) begin
			hold_buffer <= compare_a_value[7:0];
		end
	end

	always_comb begin
		next_rdata = 32'h0000_0000;
		next_err   = 1'b0;
		if (addr_is(paddr_i, compact_timer_pkg::ADDR_CONTROL_0)) begin
			next_rdata[7:0] = control_0;
		end else if (addr_is(paddr_i, compact_timer_pkg::ADDR_CONTROL_1)) begin
			next_rdata[7:0] = control_1;
		end else if (addr_is(paddr_i, compact_timer_pkg::ADDR_COUNTER_LOW)
			|| addr_is(paddr_i, compact_timer_pkg::ADDR_COMPARE_LOW)) begin
			next_rdata[7:0] = hold_buffer;
		end else if (addr_is(paddr_i, compact_timer_pkg::ADDR_COUNTER_HIGH)) begin
			next_rdata[1:0] = counter[9:8];
		end else if (addr_is(paddr_i, compact_timer_pkg::ADDR_COMPARE_HIGH)) begin
			next_rdata[1:0] = compare_a_value[9:8];
		end else if (addr_is(paddr_i, compact_timer_pkg::ADDR_STATUS)) begin
			next_rdata[compact_timer_pkg::ST_MATCH_A] = match_a_flag;
			next_rdata[compact_timer_pkg::ST_MATCH_P] = match_p_flag;
		end else if (addr_is(paddr_i, compact_timer_pkg::ADDR_SUB_DIVIDE)) begin
			next_rdata[15:0] = sub_divide;
		end else begin
			next_err = 1'b1;
		end
	end

	// read data is loaded at the setup edge and stands through the access phase;
	// the counter low byte is snapshotted at the same edge so both halves agree
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			prdata_o         <= 32'h0000_0000;
			counter_low_snap <= 8'h00;
		end else if (psel_i && !penable_i && !pwrite_i) begin
			prdata_o         <= next_rdata;
			counter_low_snap <= counter[7:0];
		end else begin
			prdata_o         <= 32'h0000_0000;
		end
	end

	assign pslverr_o = psel_i && penable_i && next_err;

	// ================================================================
	// counter
	timer_tick_gen u_tick (
		.clk_i         (clk_i),
		.rst_i         (rst_i),
		.clock_select_i(clock_select),
		.sub_divide_i  (sub_divide),
		.tick_o        (tick)
	);

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			run_prev <= 1'b0;
		end else begin
			run_prev <= run_enable;
		end
	end

	assign run_rise = run_enable && !run_prev;
	assign advance  = tick && run_enable && !pause_bit;
	assign match_a  = advance && (counter == compare_a_value) && (compare_a_value != 10'h000);
	assign match_p  = advance && (counter[9:7] == period_field) && (period_field != 3'b000);
	assign overflow = advance && (counter == compact_timer_pkg::COUNT_MAX);

	always_comb begin
		if (mode_select == compact_timer_pkg::MODE_PWM) begin
			clear_cnt = duty_period_swap ? match_a : (match_p || overflow);
		end else if (clear_select) begin
			clear_cnt = match_a || overflow;
		end else begin
			clear_cnt = match_p || overflow;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i || run_rise) begin
			counter <= 10'h000;
		end else if (clear_cnt) begin
			counter <= 10'h000;
		end else if (advance) begin
			counter <= counter + 10'h001;
		end
	end

	// ================================================================
	// match flags: set wins over software clear (write one to clear)
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			match_a_flag <= 1'b0;
			match_p_flag <= 1'b0;
		end else begin
			if (match_a) begin
				match_a_flag <= 1'b1;
			end else if (wr_acc && addr_is(paddr_i, compact_timer_pkg::ADDR_STATUS)
				&& pwdata_i[compact_timer_pkg::ST_MATCH_A]) begin
				match_a_flag <= 1'b0;
			end
			if (match_p && !(clear_select && mode_select != compact_timer_pkg::MODE_PWM)) begin
				match_p_flag <= 1'b1;
			end else if (wr_acc && addr_is(paddr_i, compact_timer_pkg::ADDR_STATUS)
				&& pwdata_i[compact_timer_pkg::ST_MATCH_P]) begin
				match_p_flag <= 1'b0;
			end
		end
	end

	assign match_a_flag_o = match_a_flag;
	assign match_p_flag_o = match_p_flag;

	// ================================================================
	// output stage
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			out_level <= 1'b0;
		end else if (run_rise) begin
			out_level <= output_initial_level;
		end else if (mode_select == compact_timer_pkg::MODE_COMPARE && match_a) begin
			case (output_function)
				2'b01:   out_level <= 1'b0;
				2'b10:   out_level <= 1'b1;
				2'b11:   out_level <= !out_level;
				default: out_level <= out_level;
			endcase
		end
	end

	// pwm active while counter is below the duty compare
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			pwm_raw <= 1'b0;
		end else if (duty_period_swap) begin
			pwm_raw <= (counter[9:7] < period_field);
		end else begin
			pwm_raw <= (counter < compare_a_value);
		end
	end

	always_comb begin
		case (mode_select)
			compact_timer_pkg::MODE_PWM: begin
				case (output_function)
					2'b00:   main_level = !output_initial_level;
					2'b01:   main_level = output_initial_level;
					2'b10:   main_level = pwm_raw ? output_initial_level : !output_initial_level;
					default: main_level = !output_initial_level;
				endcase
			end
			compact_timer_pkg::MODE_TIMER: main_level = 1'b0;
			default:                       main_level = out_level;
		endcase
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			timer_out_o          <= 1'b0;
			timer_out_inverted_o <= 1'b1;
		end else begin
			timer_out_o          <= main_level ^ (output_polarity && mode_select != compact_timer_pkg::MODE_TIMER);
			timer_out_inverted_o <= !(main_level ^ (output_polarity && mode_select != compact_timer_pkg::MODE_TIMER));
		end
	end

	// ================================================================
	// assertions
	AST_INVERTED: assert property (@(posedge clk_i) disable iff (rst_i)
		timer_out_inverted_o == !timer_out_o) else $error("inverted output mismatch");
	AST_RUN_CLEAR: assert property (@(posedge clk_i) disable iff (rst_i)
		run_rise |=> counter == 10'h000) else $error("counter not cleared on run rise");
	AST_HOLD: assert property (@(posedge clk_i) disable iff (rst_i)
		(pause_bit || !run_enable) && !run_rise |=> $stable(counter)) else $error("counter moved while held");
	AST_STEP: assert property (@(posedge clk_i) disable iff (rst_i)
		advance && !clear_cnt && !run_rise |=> counter == $past(counter) + 10'h001) else $error("bad step");
	AST_MATCH_A: assert property (@(posedge clk_i) disable iff (rst_i)
		match_a |=> match_a_flag) else $error("match a flag missing");
	AST_P_CLEAR: assert property (@(posedge clk_i) disable iff (rst_i)
		match_p && !clear_select && mode_select == compact_timer_pkg::MODE_COMPARE && !run_rise
		|=> counter == 10'h000) else $error("p match did not clear");
	AST_COMMIT: assert property (@(posedge clk_i) disable iff (rst_i)
		wr_acc && paddr_i == compact_timer_pkg::ADDR_COMPARE_HIGH
		|=> compare_a_value[7:0] == $past(hold_buffer)) else $error("low byte not committed");
	AST_INIT_LEVEL: assert property (@(posedge clk_i) disable iff (rst_i)
		run_rise |=> out_level == $past(output_initial_level)) else $error("initial level not set");
	AST_TOGGLE: assert property (@(posedge clk_i) disable iff (rst_i)
		mode_select == compact_timer_pkg::MODE_COMPARE && match_a && output_function == 2'b11 && !run_rise
		|=> out_level != $past(out_level)) else $error("toggle missed");
	AST_OVERFLOW: assert property (@(posedge clk_i) disable iff (rst_i)
		overflow && !run_rise |=> counter == 10'h000) else $error("overflow did not clear");
	AST_A_CLEAR: assert property (@(posedge clk_i) disable iff (rst_i)
		match_a && clear_select && mode_select == compact_timer_pkg::MODE_COMPARE && !run_rise
		|=> counter == 10'h000) else $error("a match did not clear");
	AST_P_SUPPRESS: assert property (@(posedge clk_i) disable iff (rst_i)
		clear_select && mode_select == compact_timer_pkg::MODE_COMPARE && !match_p_flag
		|=> !match_p_flag) else $error("p flag set while a clears");
	AST_POLARITY: assert property (@(posedge clk_i) disable iff (rst_i)
		mode_select == compact_timer_pkg::MODE_COMPARE
		|=> timer_out_o == ($past(out_level) ^ $past(output_polarity))) else $error("polarity wrong");
	AST_PWM_ACTIVE: assert property (@(posedge clk_i) disable iff (rst_i)
		mode_select == compact_timer_pkg::MODE_PWM && output_function == 2'b01
		|=> timer_out_o == ($past(output_initial_level) ^ $past(output_polarity)))
		else $error("pwm active level not forced");
	AST_SNAPSHOT: assert property (@(posedge clk_i) disable iff (rst_i)
		rd_acc && paddr_i == compact_timer_pkg::ADDR_COUNTER_HIGH
		|=> hold_buffer == $past(counter[7:0], 2)) else $error("low byte not captured");
	COV_MATCH_A: cover property (@(posedge clk_i) disable iff (rst_i) match_a);
	COV_OVERFLOW: cover property (@(posedge clk_i) disable iff (rst_i) overflow);
	COV_PWM: cover property (@(posedge clk_i) disable iff (rst_i)
		mode_select == compact_timer_pkg::MODE_PWM && $rose(timer_out_o));
	COV_MATCH_P: cover property (@(posedge clk_i) disable iff (rst_i) match_p);
	COV_TOGGLE: cover property (@(posedge clk_i) disable iff (rst_i)
		mode_select == compact_timer_pkg::MODE_COMPARE && match_a && output_function == 2'b11);
endmodule // compact_timer

// file: rtl/compact_timer_pkg.sv
// package: register map, field positions, reset values and enumerations of the compact timer
// assumes: a 250 MHz system clock and an apb slave with 32-bit data
package compact_timer_pkg;
	// register byte addresses on apb
	localparam logic [7:0] ADDR_CONTROL_0    = 8'h00;
	localparam logic [7:0] ADDR_CONTROL_1    = 8'h04;
	localparam logic [7:0] ADDR_COUNTER_LOW  = 8'h08;
	localparam logic [7:0] ADDR_COUNTER_HIGH = 8'h0c;
	localparam logic [7:0] ADDR_COMPARE_LOW  = 8'h10;
	localparam logic [7:0] ADDR_COMPARE_HIGH = 8'h14;
	localparam logic [7:0] ADDR_STATUS       = 8'h18;
	localparam logic [7:0] ADDR_SUB_DIVIDE   = 8'h1c;

	// timer_control_0 fields
	localparam int C0_PAUSE      = 7;
	localparam int C0_CLKSEL_LSB = 4;
	localparam int C0_RUN        = 3;
	localparam int C0_PERIOD_LSB = 0;
	// timer_control_1 fields
	localparam int C1_MODE_LSB   = 6;
	localparam int C1_OUTFN_LSB  = 4;
	localparam int C1_INIT_LEVEL = 3;
	localparam int C1_POLARITY   = 2;
	localparam int C1_SWAP       = 1;
	localparam int C1_CLEAR_SEL  = 0;
	// status fields
	localparam int ST_MATCH_A    = 0;
	localparam int ST_MATCH_P    = 1;

	localparam logic [7:0]  CONTROL_RESET  = 8'h00;
	localparam logic [9:0]  COUNT_MAX      = 10'h3ff;
	localparam int          PERIOD_SHIFT   = 7;
	localparam logic [15:0] SUB_DIV_RESET  = 16'h1e84;
	localparam logic [5:0]  HIGH_DIV_16    = 6'h0f;
	localparam logic [5:0]  HIGH_DIV_64    = 6'h3f;
	localparam logic [5:0]  SYS_DIV_4      = 6'h03;

	typedef enum logic [1:0] {
		MODE_COMPARE = 2'b00,
		MODE_UNDEF   = 2'b01,
		MODE_PWM     = 2'b10,
		MODE_TIMER   = 2'b11
	} mode_e;

	typedef enum logic [2:0] {
		CLK_SYS_DIV4  = 3'b000,
		CLK_SYS       = 3'b001,
		CLK_HIGH_D16  = 3'b010,
		CLK_HIGH_D64  = 3'b011,
		CLK_SUB_A     = 3'b100,
		CLK_SUB_B     = 3'b101,
		CLK_UNDEF_A   = 3'b110,
		CLK_UNDEF_B   = 3'b111
	} clock_sel_e;
endpackage

// file: rtl/timer_tick_gen.sv
// holds: enable-pulse dividers that make the selectable timer clock ticks
// assumes: one clock; every slower rate is a one-cycle enable
`timescale 1ns/10ps
module timer_tick_gen (
	input  wire logic        clk_i,
	input  wire logic        rst_i,
	input  wire logic [2:0]  clock_select_i,
	input  wire logic [15:0] sub_divide_i,
	output logic             tick_o
);
	logic [5:0]  fast_div;
	logic [15:0] sub_div;
	logic        sub_tick;

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			fast_div <= 6'h00;
		end else begin
			fast_div <= fast_div + 6'h01;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i || sub_tick) begin
			sub_div <= 16'h0000;
		end else begin
			sub_div <= sub_div + 16'h0001;
		end
	end

	assign sub_tick = (sub_div >= sub_divide_i);

	// ================================================================
	// clock source selection
	always_comb begin
		case (compact_timer_pkg::clock_sel_e'(clock_select_i))
			compact_timer_pkg::CLK_SYS_DIV4: tick_o = (fast_div[1:0] == compact_timer_pkg::SYS_DIV_4[1:0]);
			compact_timer_pkg::CLK_SYS:      tick_o = 1'b1;
			compact_timer_pkg::CLK_HIGH_D16: tick_o = (fast_div[3:0] == compact_timer_pkg::HIGH_DIV_16[3:0]);
			compact_timer_pkg::CLK_HIGH_D64: tick_o = (fast_div == compact_timer_pkg::HIGH_DIV_64);
			compact_timer_pkg::CLK_SUB_A,
			compact_timer_pkg::CLK_SUB_B:    tick_o = sub_tick;
			default:                         tick_o = 1'b0;
		endcase
	end
endmodule // timer_tick_gen

// file: sim/compact_timer_test.sv
// holds: self-checking bench for the compact timer, apb master and read monitor
// assumes: rtl/compact_timer_pkg.sv and the design files are compiled first
`timescale 1ns/10ps
module compact_timer_test;
	typedef struct {logic [31:0] data; logic err; logic chk;} read_note_s;
	logic        clk_i = 1'b0;
	logic        rst_i = 1'b1;
	logic        psel_i = 1'b0;
	logic        penable_i = 1'b0;
	logic        pwrite_i = 1'b0;
	logic [7:0]  paddr_i = 8'h00;
	logic [31:0] pwdata_i = 32'h0;
	logic [31:0] prdata_o;
	logic        pready_o, pslverr_o, match_a_flag_o, match_p_flag_o;
	logic        timer_out_o, timer_out_inverted_o;
	int          err_total = 0;
	int          samples_checked = 0;
	integer      seed = 32'hbea9f21e;
	read_note_s  exp_q[$];
	read_note_s  note;
	compact_timer u_dut (.clk_i(clk_i), .rst_i(rst_i), .psel_i(psel_i), .penable_i(penable_i),
		.pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o),
		.pready_o(pready_o), .pslverr_o(pslverr_o), .match_a_flag_o(match_a_flag_o),
		.match_p_flag_o(match_p_flag_o), .timer_out_o(timer_out_o),
		.timer_out_inverted_o(timer_out_inverted_o));
	always #2 clk_i = ~clk_i;
	// ==========================================
	// compare and closing tasks
	task automatic cmp_val(input string what, input logic [31:0] exp, input logic [31:0] got);
		samples_checked++;
		if (got !== exp) begin
			err_total++;
			$display("FAIL %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic cmp_range(input string what, input int lo, input int hi, input logic [31:0] got);
		samples_checked++;
		if (^got === 1'bx || got < lo || got > hi) begin
			err_total++;
			$display("FAIL %s expected %0d..%0d seen %0d", what, lo, hi, got);
		end
	endtask
	task automatic conclude();
		if (err_total == 0 && samples_checked > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	// ==========================================
	// apb master
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
			input logic [31:0] exp, input logic eerr, input logic chk, output logic [31:0] rd);
		int n;
		n = 0;
		if (!w)
			exp_q.push_back('{exp, eerr, chk});
		psel_i <= 1'b1; pwrite_i <= w; paddr_i <= a; pwdata_i <= d; penable_i <= 1'b0;
		@(posedge clk_i);
		penable_i <= 1'b1;
		do begin
			@(posedge clk_i);
			n++;
		end while (pready_o !== 1'b1 && n < 50);
		if (n >= 50) begin
			cmp_val("pready", 32'h1, 32'h0);
			conclude();
		end
		rd = prdata_o;
		psel_i <= 1'b0; penable_i <= 1'b0;
		@(posedge clk_i);
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] rd;
		apb(1'b1, a, d, 32'h0, 1'b0, 1'b0, rd);
	endtask
	task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp, input logic eerr);
		logic [31:0] rd;
		apb(1'b0, a, 32'h0, exp, eerr, 1'b1, rd);
	endtask
	task automatic rd_cnt(output logic [9:0] cnt);
		logic [31:0] h, l;
		apb(1'b0, compact_timer_pkg::ADDR_COUNTER_HIGH, 32'h0, 32'h0, 1'b0, 1'b0, h);
		apb(1'b0, compact_timer_pkg::ADDR_COUNTER_LOW, 32'h0, 32'h0, 1'b0, 1'b0, l);
		cnt = {h[1:0], l[7:0]};
	endtask
	task automatic set_cmp(input logic [9:0] v);
		wr(compact_timer_pkg::ADDR_COMPARE_LOW, {24'h0, v[7:0]});
		wr(compact_timer_pkg::ADDR_COMPARE_HIGH, {30'h0, v[9:8]});
	endtask
	function automatic logic [31:0] c0(logic p, logic [2:0] ck, logic r, logic [2:0] pr);
		return {24'h0, p, ck, r, pr};
	endfunction
	function automatic logic [31:0] c1(logic [1:0] m, logic [1:0] f, logic i, logic o, logic [1:0] c);
		return {24'h0, m, f, i, o, c};
	endfunction
	// ==========================================
	// monitor: oldest note against each completed read, and the output pair
	always @(posedge clk_i) begin
		if (psel_i && penable_i && pready_o === 1'b1 && !pwrite_i && exp_q.size() > 0) begin
			note = exp_q.pop_front();
			if (note.chk) begin
				cmp_val("prdata", note.data, prdata_o);
				cmp_val("pslverr", {31'h0, note.err}, {31'h0, pslverr_o});
			end
		end
		if (!rst_i)
			cmp_val("out_pair", {31'h0, ~timer_out_o}, {31'h0, timer_out_inverted_o});
	end
	initial begin
		repeat (60000) @(posedge clk_i);
		err_total++;
		conclude();
	end
	// ==========================================
	// main sequence
	initial begin
		logic [9:0] v, a, b;
		int         hi;
		logic [1:0] fn;
		logic [2:0] cks[7] = '{3'b000, 3'b001, 3'b010, 3'b011, 3'b100, 3'b101, 3'b110};
		int         los[7] = '{158, 640, 39, 9, 63, 63, 0};
		int         his[7] = '{163, 646, 42, 11, 66, 66, 0};
		repeat (16) @(posedge clk_i);
		rst_i <= 1'b0;
		@(posedge clk_i);
		rd_chk(compact_timer_pkg::ADDR_CONTROL_0, 32'h0, 1'b0);
		rd_chk(compact_timer_pkg::ADDR_CONTROL_1, 32'h0, 1'b0);
		rd_chk(compact_timer_pkg::ADDR_STATUS, 32'h0, 1'b0);
		rd_chk(compact_timer_pkg::ADDR_SUB_DIVIDE, {16'h0, compact_timer_pkg::SUB_DIV_RESET}, 1'b0);
		wr(compact_timer_pkg::ADDR_CONTROL_1, 32'h000000a5);
		rd_chk(compact_timer_pkg::ADDR_CONTROL_1, 32'h000000a5, 1'b0);
		wr(compact_timer_pkg::ADDR_CONTROL_1, 32'h0);
		wr(compact_timer_pkg::ADDR_COUNTER_HIGH, 32'h3);
		wr(compact_timer_pkg::ADDR_COUNTER_LOW, 32'h55);
		rd_chk(compact_timer_pkg::ADDR_COUNTER_HIGH, 32'h0, 1'b0);
		rd_chk(compact_timer_pkg::ADDR_COUNTER_LOW, 32'h0, 1'b0);
		rd_chk(8'h20, 32'h0, 1'b1);
		v = $random(seed);
		wr(compact_timer_pkg::ADDR_COMPARE_LOW, {24'h0, v[7:0]});
		rd_chk(compact_timer_pkg::ADDR_COMPARE_HIGH, 32'h0, 1'b0);
		rd_chk(compact_timer_pkg::ADDR_COMPARE_LOW, 32'h0, 1'b0);
		wr(compact_timer_pkg::ADDR_COMPARE_LOW, {24'h0, v[7:0]});
		wr(compact_timer_pkg::ADDR_COMPARE_HIGH, {30'h0, v[9:8]});
		rd_chk(compact_timer_pkg::ADDR_COMPARE_HIGH, {30'h0, v[9:8]}, 1'b0);
		rd_chk(compact_timer_pkg::ADDR_COMPARE_LOW, {24'h0, v[7:0]}, 1'b0);
		// counter rate for every defined clock code and one undefined code
		wr(compact_timer_pkg::ADDR_SUB_DIVIDE, 32'h9);
		wr(compact_timer_pkg::ADDR_CONTROL_1, c1(compact_timer_pkg::MODE_TIMER, 2'b00, 0, 0, 0));
		for (int k = 0; k < 7; k++) begin
			wr(compact_timer_pkg::ADDR_CONTROL_0, c0(0, cks[k], 1, 3'b000));
			repeat (640) @(posedge clk_i);
			wr(compact_timer_pkg::ADDR_CONTROL_0, c0(0, cks[k], 0, 3'b000));
			rd_cnt(a);
			cmp_range("count_rate", los[k], his[k], {22'h0, a});
			repeat (40) @(posedge clk_i);
			rd_cnt(b);
			cmp_val("count_held", {22'h0, a}, {22'h0, b});
		end
		wr(compact_timer_pkg::ADDR_SUB_DIVIDE, 32'hffff);
		wr(compact_timer_pkg::ADDR_CONTROL_0, c0(0, 3'b100, 1, 3'b000));
		rd_cnt(a);
		cmp_val("count_cleared", 32'h0, {22'h0, a});
		// pause holds and resumes
		wr(compact_timer_pkg::ADDR_CONTROL_0, c0(0, 3'b001, 0, 3'b000));
		wr(compact_timer_pkg::ADDR_CONTROL_0, c0(0, 3'b001, 1, 3'b000));
		repeat (100) @(posedge clk_i);
		wr(compact_timer_pkg::ADDR_CONTROL_0, c0(1, 3'b001, 1, 3'b000));
		rd_cnt(a);
		repeat (50) @(posedge clk_i);
		rd_cnt(b);
		cmp_val("paused", {22'h0, a}, {22'h0, b});
		wr(compact_timer_pkg::ADDR_CONTROL_0, c0(0, 3'b001, 1, 3'b000));
		repeat (100) @(posedge clk_i);
		rd_cnt(b);
		cmp_range("resumed", a + 100, a + 110, {22'h0, b});
		// match flags and clearing sources
		for (int c = 0; c < 2; c++) begin
			wr(compact_timer_pkg::ADDR_CONTROL_0, c0(0, 3'b001, 0, 3'b001));
			wr(compact_timer_pkg::ADDR_CONTROL_1, c1(compact_timer_pkg::MODE_COMPARE, 0, 0, 0, c));
			set_cmp(c ? 10'd40 : 10'd64);
			wr(compact_timer_pkg::ADDR_STATUS, 32'h3);
			wr(compact_timer_pkg::ADDR_CONTROL_0, c0(0, 3'b001, 1, 3'b001));
			repeat (300) @(posedge clk_i);
			rd_chk(compact_timer_pkg::ADDR_STATUS, c ? 32'h1 : 32'h3, 1'b0);
			cmp_val("match_a_flag_o", 32'h1, {31'h0, match_a_flag_o});
			cmp_val("match_p_flag_o", c ? 32'h0 : 32'h1, {31'h0, match_p_flag_o});
			rd_cnt(a);
			cmp_range("clear_bound", 0, c ? 40 : 128, {22'h0, a});
		end
		wr(compact_timer_pkg::ADDR_CONTROL_0, c0(0, 3'b001, 0, 3'b000));
		wr(compact_timer_pkg::ADDR_STATUS, 32'h3);
		rd_chk(compact_timer_pkg::ADDR_STATUS, 32'h0, 1'b0);
		// compare output action for every function, initial level and polarity
		set_cmp(10'd50);
		for (int i = 0; i < 16; i++) begin
			wr(compact_timer_pkg::ADDR_CONTROL_0, c0(0, 3'b001, 0, 3'b000));
			wr(compact_timer_pkg::ADDR_CONTROL_1,
				c1(compact_timer_pkg::MODE_COMPARE, i[1:0], i[2], i[3], 0));
			wr(compact_timer_pkg::ADDR_CONTROL_0, c0(0, 3'b001, 1, 3'b000));
			repeat (10) @(posedge clk_i);
			cmp_val("out_initial", {31'h0, i[2] ^ i[3]}, {31'h0, timer_out_o});
			repeat (300) @(posedge clk_i);
			case (i[1:0])
				2'b00: v[0] = i[2];
				2'b01: v[0] = 1'b0;
				2'b10: v[0] = 1'b1;
				default: v[0] = ~i[2];
			endcase
			cmp_val("out_match", {31'h0, v[0] ^ i[3]}, {31'h0, timer_out_o});
		end
		// pwm: forced inactive, forced active, duty 32 of 128, then roles swapped
		set_cmp(10'd32);
		for (int f = 0; f < 4; f++) begin
			wr(compact_timer_pkg::ADDR_CONTROL_0, c0(0, 3'b001, 0, 3'b001));
			fn = (f == 3) ? 2'b10 : f[1:0];
			wr(compact_timer_pkg::ADDR_CONTROL_1,
				c1(compact_timer_pkg::MODE_PWM, fn, 1, 0, {f == 3, 1'b0}));
			wr(compact_timer_pkg::ADDR_CONTROL_0, c0(0, 3'b001, 1, 3'b001));
			repeat (20) @(posedge clk_i);
			hi = 0;
			repeat (512) begin
				@(posedge clk_i);
				hi += (timer_out_o === 1'b1);
			end
			cmp_range("pwm_high", f == 2 ? 124 : (f == 0 ? 0 : 512),
				f == 2 ? 132 : (f == 0 ? 0 : 512), hi);
		end
		conclude();
	end
endmodule // compact_timer_test
